/* File: hw/aasc_control_word.sv */
// How it works
// - preamble bits three to six carry the part reference, checked on receipt.
// - last preamble bits: 11 reads the word, 10 writes it.
// - one 64-bit control word, loaded from each accepted write frame.
// - word travels msb first, bit 0 last in the frame.
// - after reset all word bits are zero except documented defaults.
// - left volume in bits 0-8, right volume in bits 9-17.
// - code 0FE is 0 dB, 130 is +25 dB, 040 is soft mute.
// - both volumes reset to 0FA (-2 dB); 041 gives -94.5 dB.
// - bit 18 picks bass boost (1) or cut (0).
// - bits 19-22 give bass magnitude, 0 to 15 dB.
// - bits 23-24 select the bass corner frequency.
// - bit 25 picks treble boost (1) or cut (0).
// - bits 26-29 give treble magnitude, 0 to 15 dB.
// - bits 30-31 select the treble corner frequency.
// - enable is active low and stays low exactly 72 clocks.
// - frames not exactly 72 bits long are discarded, word unchanged.
// - read: data pin turns to output on falling edge after direction bit.
`timescale 1ns/1ps

module aasc_control_word
	import aasc_pkg::*;
#(
	parameter logic [3:0] PART_REF    = 4'h5,	// arbitrary value
	parameter int         SYNC_STAGES = 2
) (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       serial_clock,
	input  wire logic       serial_enable_n,
	input  wire logic       serial_data_i,
	output logic            serial_data_o,
	output logic            serial_data_oe,
	output aasc_word_s      audio_control_word,
	output logic            left_soft_mute,
	output logic            right_soft_mute,
	output logic            bass_corner_reserved,
	output logic            treble_corner_reserved,
	output logic            frame_accepted,
	output logic            frame_rejected
);

	// refuse settings the crossing cannot serve
	if (SYNC_STAGES < 2) begin : g_bad_sync
		$error("SYNC_STAGES must be at least 2");
	end

	// the counter must reach one past a full frame to tell 73 from 72
	if ((2 ** CNT_W) <= FRAME_BITS + 1) begin : g_bad_count
		$error("CNT_W too narrow for the frame length");
	end

	// preamble struct must cover the preamble exactly
	if ($bits(aasc_pre_s) != PRE_BITS) begin : g_bad_pre
		$error("preamble struct does not match PRE_BITS");
	end

	// word struct must cover the control word exactly
	if ($bits(aasc_word_s) != WORD_BITS) begin : g_bad_word
		$error("word struct does not match WORD_BITS");
	end

	// master-domain state
	typedef struct packed {
		logic [SYNC_STAGES-1:0] en_sync;
		logic                   en_last;
		logic                   link_clr;
		aasc_word_s             word;
		logic                   left_mute;
		logic                   right_mute;
		logic                   bass_rsv;
		logic                   treble_rsv;
		logic                   accepted;
		logic                   rejected;
	} mst_s;

	// link-domain receive state, rising edge of the serial clock
	typedef struct packed {
		logic [CNT_W-1:0]      count;
		logic [FRAME_BITS-1:0] shift;
	} rx_s;

	// link-domain transmit state, falling edge of the serial clock
	typedef struct packed {
		logic       drive;
		logic [5:0] idx;
		logic       bit_out;
	} tx_s;

	// registers of both domains and the frame-open flag
	mst_s m_q;
	mst_s m_d;
	rx_s  rx_q;
	rx_s  rx_d;
	tx_s  tx_q;
	tx_s  tx_d;
	logic in_frame_q;

	// read-back index must reach every bit of the word
	if ((2 ** $bits(tx_q.idx)) < WORD_BITS) begin : g_bad_idx
		$error("read-back index too narrow for the word");
	end

	// preamble decode and frame verdicts
	aasc_pre_s  rd_pre;
	aasc_pre_s  end_pre;
	logic       rd_pre_ok;
	logic       end_pre_ok;
	logic       len_ok;
	logic       rd_ok;
	logic       wr_ok;
	logic       rd_end_ok;
	logic       end_pulse;

	// preamble as seen once eight bits are in, and at the end of the frame
	assign rd_pre  = aasc_pre_s'(rx_q.shift[PRE_BITS-1:0]);
	assign end_pre = aasc_pre_s'(rx_q.shift[FRAME_BITS-1:WORD_BITS]);

	// part reference match
	// early check, on the first eight bits, for the read turn-around
	assign rd_pre_ok = (rd_pre.prefix == PREFIX_VALUE)
		&& (rd_pre.part_ref == PART_REF);

	// part reference match
	// late check, on the preamble once the whole frame is in
	assign end_pre_ok = (end_pre.prefix == PREFIX_VALUE)
		&& (end_pre.part_ref == PART_REF);

	assign len_ok = (rx_q.count == CNT_FULL);

	assign rd_ok = rd_pre_ok && (rd_pre.direction == DIR_READ);

	assign wr_ok = len_ok && end_pre_ok && (end_pre.direction == DIR_WRITE);

	// a complete read is neither loaded nor counted as a discard
	assign rd_end_ok = len_ok && end_pre_ok && (end_pre.direction == DIR_READ);

	// link domain: only the clear pulse and the stored word come in here;
	// the clear lands while the serial clock is stopped between frames,
	// and the word cannot change while a read frame is open

	// frame-open flag; cleared the moment enable goes high
	// the first edge of a frame restarts the count from one
	always_ff @(posedge serial_clock or posedge serial_enable_n or posedge m_q.link_clr) begin
		if (serial_enable_n || m_q.link_clr) begin
			in_frame_q <= 1'b0;
		end else begin
			in_frame_q <= 1'b1;
		end
	end

	// bit counter and shifter; edges while enable is high are ignored,
	// so the count and data stay frozen for the master to inspect
	always_comb begin
		rx_d = rx_q;
		if (!serial_enable_n) begin
			if (!in_frame_q) begin
				rx_d.count = CNT_W'(1);
			end else if (rx_q.count != CNT_OVER) begin
				rx_d.count = rx_q.count + CNT_W'(1);
			end

			// shift in on the serial clock
			if (!in_frame_q || rx_q.count != CNT_OVER) begin
				rx_d.shift = {rx_q.shift[FRAME_BITS-2:0], serial_data_i};
			end
		end
	end

	// cleared by the master after each frame has been judged
	// asynchronous clear: the serial clock is stopped when it arrives
	always_ff @(posedge serial_clock or posedge m_q.link_clr) begin
		if (m_q.link_clr) begin
			rx_q <= '0;
		end else begin
			rx_q <= rx_d;
		end
	end

	// read-back shifter; the word is quasi-static here because the master
	// only updates it after a frame ends, never while a read is running
	always_comb begin
		tx_d = tx_q;
		// turn around after the direction bit
		if (!tx_q.drive) begin
			if (rx_q.count == CNT_PRE && rd_ok) begin
				// drive on, msb out, index to the next bit
				tx_d.drive   = 1'b1;
				tx_d.bit_out = m_q.word[WORD_BITS-1];
				tx_d.idx     = 6'(WORD_BITS - 2);
			end
		end else begin
			// msb first, bit 0 last; holds bit 0 if clocks run on
			tx_d.bit_out = m_q.word[tx_q.idx];
			if (tx_q.idx != 6'h00) begin
				tx_d.idx = tx_q.idx - 6'h01;
			end
		end
	end

	// driver released whenever enable is high
	// released at once, not on the next clock, so the host never fights it
	always_ff @(negedge serial_clock or posedge serial_enable_n or posedge m_q.link_clr) begin
		if (serial_enable_n || m_q.link_clr) begin
			tx_q <= '0;
		end else begin
			tx_q <= tx_d;
		end
	end

	// data line straight from the falling-edge flops
	assign serial_data_o  = tx_q.bit_out;
	assign serial_data_oe = tx_q.drive;

	// master domain: enable comes in through the synchroniser, and the
	// count and shifter are read only once enable has been seen high,
	// by which time the serial clock has stopped

	// end of frame is the synchronised rising edge of enable
	assign end_pulse = m_q.en_sync[SYNC_STAGES-1] && !m_q.en_last;

	// master next state: synchroniser, frame verdict, decoded flags
	always_comb begin
		m_d = m_q;
		// first stage feeds only the second
		m_d.en_sync  = {m_q.en_sync[SYNC_STAGES-2:0], serial_enable_n};
		m_d.en_last  = m_q.en_sync[SYNC_STAGES-1];

		// status pulses last one cycle
		m_d.accepted = 1'b0;
		m_d.rejected = 1'b0;
		// link data is frozen for the gap, safe to sample here
		// the clear pulse that follows empties the link for the next frame
		m_d.link_clr = end_pulse;
		if (end_pulse) begin
			if (wr_ok) begin
				// only after a complete valid write
				m_d.word     = aasc_word_s'(rx_q.shift[WORD_BITS-1:0]);
				m_d.accepted = 1'b1;
			end else if (!rd_end_ok) begin
				m_d.rejected = 1'b1;
			end
		end

		// flags track the word being stored, so they move with it
		// volume fields by position
		m_d.left_mute  = (m_d.word.tone.left_volume_code == VOL_SOFT_MUTE);
		m_d.right_mute = (m_d.word.tone.right_volume_code == VOL_SOFT_MUTE);
		// bass corner code 11 has no meaning
		m_d.bass_rsv   = (m_d.word.tone.bass_corner_select == CORNER_RESERVED);
		// treble corner code 11 has no meaning
		m_d.treble_rsv = (m_d.word.tone.treble_corner_select == CORNER_RESERVED);

		// synchronous reset overrides everything above
		if (!nrst) begin
			m_d.word       = WORD_RESET;
			m_d.en_sync    = '1;
			m_d.en_last    = 1'b1;
			m_d.link_clr   = 1'b1;	// holds the link empty through reset
			m_d.left_mute  = 1'b0;
			m_d.right_mute = 1'b0;
			m_d.bass_rsv   = 1'b0;
			m_d.treble_rsv = 1'b0;
			m_d.accepted   = 1'b0;
			m_d.rejected   = 1'b0;
		end
	end

	// one register for all master-domain state
	always_ff @(posedge ref_clk) begin
		m_q <= m_d;
	end

	// fields reach the audio path by position
	assign audio_control_word     = m_q.word;
	assign left_soft_mute         = m_q.left_mute;
	assign right_soft_mute        = m_q.right_mute;
	assign bass_corner_reserved   = m_q.bass_rsv;
	assign treble_corner_reserved = m_q.treble_rsv;

	// one-cycle verdict pulses
	assign frame_accepted         = m_q.accepted;
	assign frame_rejected         = m_q.rejected;

endmodule // aasc_control_word

/* File: hw/aasc_pkg.sv */
package aasc_pkg;

	// frame layout: preamble then control word, both msb first
	localparam int PRE_BITS   = 8;
	localparam int WORD_BITS  = 64;
	localparam int FRAME_BITS = PRE_BITS + WORD_BITS;
	localparam int CNT_W      = 7;
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FRAME_BITS);
	localparam logic [CNT_W-1:0] CNT_OVER = CNT_W'(FRAME_BITS + 1);
	localparam logic [CNT_W-1:0] CNT_PRE  = CNT_W'(PRE_BITS);

	// preamble fields: prefix, part reference, direction
	localparam logic [1:0] PREFIX_VALUE = 2'h0;
	localparam logic [1:0] DIR_READ     = 2'h3;
	localparam logic [1:0] DIR_WRITE    = 2'h2;

	// volume codes, 0.5 dB steps
	localparam logic [8:0] VOL_RESET     = 9'h0FA;
	localparam logic [8:0] VOL_UNITY     = 9'h0FE;
	localparam logic [8:0] VOL_MAX       = 9'h130;
	localparam logic [8:0] VOL_MIN       = 9'h041;
	localparam logic [8:0] VOL_SOFT_MUTE = 9'h040;

	// tone corner encodings
	localparam logic [1:0] BASS_CORNER_LOW    = 2'h0;
	localparam logic [1:0] BASS_CORNER_MID    = 2'h1;
	localparam logic [1:0] BASS_CORNER_HIGH   = 2'h2;
	localparam logic [1:0] TREBLE_CORNER_4K   = 2'h0;
	localparam logic [1:0] TREBLE_CORNER_8K   = 2'h1;
	localparam logic [1:0] TREBLE_CORNER_12K  = 2'h2;
	localparam logic [1:0] CORNER_RESERVED    = 2'h3;

	// preamble as received, msb first
	typedef struct packed {
		logic [1:0] prefix;
		logic [3:0] part_ref;
		logic [1:0] direction;
	} aasc_pre_s;

	// low half of the control word, field order bit 31 down to bit 0
	typedef struct packed {
		logic [1:0] treble_corner_select;
		logic [3:0] treble_gain_magnitude;
		logic       treble_direction_select;
		logic [1:0] bass_corner_select;
		logic [3:0] bass_gain_magnitude;
		logic       bass_direction_select;
		logic [8:0] right_volume_code;
		logic [8:0] left_volume_code;
	} aasc_tone_s;

	// whole 64-bit control word; upper half stored but not decoded here
	typedef struct packed {
		logic [31:0] upper_bits;
		aasc_tone_s  tone;
	} aasc_word_s;

	localparam aasc_word_s WORD_RESET = '{
		upper_bits: 32'h0000_0000,
		tone: '{
			treble_corner_select:    2'h0,
			treble_gain_magnitude:   4'h0,
			treble_direction_select: 1'h0,
			bass_corner_select:      2'h0,
			bass_gain_magnitude:     4'h0,
			bass_direction_select:   1'h0,
			right_volume_code:       VOL_RESET,
			left_volume_code:        VOL_RESET
		}
	};

endpackage

/* File: sim/aasc_control_word_bench.sv */
`timescale 1ns/1ps
module aasc_control_word_bench
	import aasc_pkg::*;
;
	localparam logic [3:0] REF = 4'h5;	// arbitrary part reference
	localparam logic [7:0] WR  = {PREFIX_VALUE, REF, DIR_WRITE};
	localparam logic [7:0] RD  = {PREFIX_VALUE, REF, DIR_READ};
	logic        ref_clk, nrst, sck, en_n, din, dout, oe, lm, rm, bres, tres, acc, rej;
	aasc_word_s  word;
	logic [63:0] rd;
	int          bad_count = 0, n_checks = 0, acc_n = 0, rej_n = 0, oe_n = 0;
	aasc_control_word #(.PART_REF(REF)) dut (.ref_clk, .nrst, .serial_clock(sck),
		.serial_enable_n(en_n), .serial_data_i(din), .serial_data_o(dout),
		.serial_data_oe(oe), .audio_control_word(word), .left_soft_mute(lm),
		.right_soft_mute(rm), .bass_corner_reserved(bres), .treble_corner_reserved(tres),
		.frame_accepted(acc), .frame_rejected(rej));
	aasc_host_model host (.sck, .en_n, .din, .dout, .oe);
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// pulses last one cycle and the host task outlives them, so tally them
	always @(posedge ref_clk) begin
		acc_n += int'(acc === 1'b1);
		rej_n += int'(rej === 1'b1);
	end
	always @(posedge oe) oe_n++;
	task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic t_reset();
		chk("reset word", WORD_RESET, word);
		chk("reset flags", 4'h0, {lm, rm, bres, tres});
		host.frame(RD, '0, 72, rd);
		chk("reset read", WORD_RESET, rd);
		$display("reset test done");
	endtask
	task automatic t_fields();
		aasc_word_s v;
		int a, o;
		v = {32'hA5C3_0F96, CORNER_RESERVED, 4'hF, 1'b1, CORNER_RESERVED, 4'hF, 1'b1,
			VOL_MAX, VOL_SOFT_MUTE};
		a = acc_n;
		o = oe_n;
		host.frame(WR, v, 72, rd);
		chk("accepted", 64'(a + 1), 64'(acc_n));
		chk("word", v, word);
		chk("flags", 4'hB, {lm, rm, bres, tres});
		host.frame(RD, '0, 72, rd);
		chk("read", v, rd);
		chk("oe", 64'(o + 1), 64'(oe_n));
		$display("field test done");
	endtask
	task automatic t_corners();
		aasc_word_s v;
		for (int c = 0; c < 3; c++) begin
			v = WORD_RESET;
			v.tone.bass_corner_select = 2'(c);
			v.tone.treble_corner_select = 2'(c);
			v.tone.right_volume_code = VOL_MIN;
			v.tone.left_volume_code = VOL_UNITY;
			host.frame(WR, v, 72, rd);
			chk("corner word", v, word);
			chk("corner flags", 4'h0, {lm, rm, bres, tres});
		end
		$display("corner test done");
	endtask
	task automatic t_bad();
		logic [7:0] p [6] = '{WR, WR, {PREFIX_VALUE, ~REF, DIR_WRITE}, {2'h1, REF, DIR_WRITE},
			{PREFIX_VALUE, REF, 2'h1}, {PREFIX_VALUE, ~REF, DIR_READ}};
		int n [6] = '{71, 73, 72, 72, 72, 72};
		aasc_word_s v;
		int r, o;
		v = word;
		for (int i = 0; i < 6; i++) begin
			r = rej_n;
			o = oe_n;
			host.frame(p[i], ~v, n[i], rd);
			chk("bad word", v, word);
			chk("bad rejected", 64'(r + 1), 64'(rej_n));
			chk("bad oe", 64'(o), 64'(oe_n));
		end
		$display("bad frame test done");
	endtask
	initial begin
		nrst = 1'b0;
		repeat (16) @(negedge ref_clk);
		nrst = 1'b1;
		repeat (4) @(negedge ref_clk);
		t_reset();
		t_fields();
		t_corners();
		t_bad();
		print_verdict();
	end
	// watchdog: the frames need well under a third of this
	initial begin
		#1_000_000;
		bad_count++;
		print_verdict();
	end
endmodule // aasc_control_word_bench

/* File: sim/aasc_control_word_checker.sv */
`timescale 1ns/1ps
// relations between the link, the word and the status pulses
module aasc_control_word_checker
	import aasc_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       nrst,
	input wire logic       serial_clock,
	input wire logic       serial_enable_n,
	input wire logic       serial_data_i,
	input wire logic       serial_data_o,
	input wire logic       serial_data_oe,
	input wire aasc_word_s audio_control_word,
	input wire logic       left_soft_mute,
	input wire logic       right_soft_mute,
	input wire logic       bass_corner_reserved,
	input wire logic       treble_corner_reserved,
	input wire logic       frame_accepted,
	input wire logic       frame_rejected
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	aasc_tone_s t;
	assign t = audio_control_word.tone;
	property p_rst; $rose(nrst) |-> audio_control_word == WORD_RESET; endproperty
	a_rst: assert property (p_rst) else $error("word not at reset value");
	property p_quiet; $changed(audio_control_word) |-> frame_accepted; endproperty
	a_quiet: assert property (p_quiet) else $error("word moved without a write");
	property p_pulse; frame_accepted |=> !frame_accepted; endproperty
	a_pulse: assert property (p_pulse) else $error("accept pulse too long");
	property p_excl; !(frame_accepted && frame_rejected); endproperty
	a_excl: assert property (p_excl) else $error("accepted and rejected together");
	// flags move with the word in the same cycle; judge them once it settles
	property p_mute; $stable(audio_control_word) |-> {left_soft_mute, right_soft_mute} ==
		{t.left_volume_code == VOL_SOFT_MUTE, t.right_volume_code == VOL_SOFT_MUTE}; endproperty
	a_mute: assert property (p_mute) else $error("soft mute flag wrong");
	property p_res; $stable(audio_control_word) |-> {bass_corner_reserved, treble_corner_reserved}
		== {t.bass_corner_select == CORNER_RESERVED, t.treble_corner_select == CORNER_RESERVED};
	endproperty
	a_res: assert property (p_res) else $error("corner flag wrong");
	property p_oe; serial_enable_n |-> !serial_data_oe; endproperty
	a_oe: assert property (p_oe) else $error("line driven outside a frame");
	property p_late; frame_accepted |-> serial_enable_n && $past(serial_enable_n, 2); endproperty
	a_late: assert property (p_late) else $error("word loaded before frame end");
	c_acc: cover property (frame_accepted);
	c_rej: cover property (frame_rejected);
	c_oe: cover property (serial_data_oe);
endmodule // aasc_control_word_checker
bind aasc_control_word aasc_control_word_checker u_chk (.ref_clk, .nrst, .serial_clock,
	.serial_enable_n, .serial_data_i, .serial_data_o, .serial_data_oe, .audio_control_word,
	.left_soft_mute, .right_soft_mute, .bass_corner_reserved, .treble_corner_reserved,
	.frame_accepted, .frame_rejected);

/* File: sim/aasc_host_model.sv */
`timescale 1ns/1ps
// host end of the link; its clock runs only inside frames
module aasc_host_model (
	output logic      sck,
	output logic      en_n,
	output logic      din,
	input  wire logic dout,
	input  wire logic oe
);
	logic drv;
	// device wins the line while it drives, otherwise the host
	assign din = oe ? dout : drv;
	initial begin
		sck = 1'b0;
		en_n = 1'b1;
		drv = 1'b0;
	end
	task automatic frame(input logic [7:0] p, input logic [63:0] w, input int n,
		output logic [63:0] rd);
		rd = '0;
		en_n = 1'b0;
		#100;
		for (int i = 0; i < n; i++) begin
			drv = (i < 8) ? p[7-i] : (i < 72) ? w[71-i] : 1'b0;
			#62.5 sck = 1'b1;
			if (i >= 8 && i < 72)
				rd[71-i] = din;
			#62.5 sck = 1'b0;
		end
		#40 en_n = 1'b1;
		// released line shows the inverse so no stale bit lingers
		drv = ~drv;
		// idle gap well over three master clocks
		#160;
	endtask
endmodule // aasc_host_model
